// ---- bdm_map.sv ----
// Purpose: banked data memory decode and mirrored core registers
// Assumes: requests come from core logic on clk_sys; porBor is a level from
//          the same domain telling whether the current reset is power-on/brown-out
// Notes:   read data valid two cycles after the request
// Function
// R1: core registers at offsets 00h-0Bh decoded the same in all banks
// R2: peripheral region occupies offsets 0Ch-1Fh after the core registers
// R3: banks 27 to 29 use that region for pin remapping instead
// R4: up to 80 bytes general purpose RAM per bank
// R5: pointers reach all general purpose RAM as one linear region
// R6: 16 bytes common RAM shared by every bank
// R7: indirect port zero accesses location addressed by pointer zero
// R8: offset 0Ah holds upper 7 PC bits, top bit zero, cleared every reset
// R9: offset 02h is PC low byte, cleared on all resets
// R10: bank select holds five bits, upper three read zero, cleared on reset
// R11: pointer high bytes clear always; low bytes only on power-on/brown-out
// R12: working register clears on power-on/brown-out, kept otherwise
// R13: unimplemented core register bits read as zero
// R14: 12-bit address, upper five bits bank, lower seven offset
// R15: thirty-two banks of 128 byte locations
// R16: reads of unimplemented locations return zero
// R17: writes to unimplemented locations or bits have no effect
`timescale 1ns/10ps
`include "bdm_defs.svh"

module bdm_map (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       porBor,
   input  wire logic       accRd,
   input  wire logic       accWr,
   input  wire logic [6:0] accOfs,
   input  wire logic [7:0] accWrData,
   input  wire logic       pcLoad,
   input  wire logic [7:0] pcLowIn,
   output logic      [7:0] rdData_ff,
   output logic            rdValid_ff,
   output logic      [4:0] bankSel_ff,
   output logic      [7:0] workReg_ff,
   output logic      [7:0] pcLow_ff,
   output logic      [6:0] pcHighBuf_ff,
   output logic      [7:0] intCtl_ff,
   output logic      [7:0] coreFlags_ff,
   output logic            periphSel_ff,
   output logic            remapSel_ff
);

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function automatic bdm_pkg::bdm_dec_type decodeAddr(input logic [11:0] a);
      logic [4:0]  bnk;
      logic [6:0]  ofs;
      bdm_pkg::bdm_dec_type d;
      bnk = a[11:7];                                                     // R14
      ofs = a[6:0];
      d.kind = bdm_pkg::KIND_NONE;
      d.idx  = 12'h000;
      if (ofs <= `BDM_CORE_LAST) begin
         d.kind = bdm_pkg::KIND_CORE;                                    // R1
         d.idx  = {8'h00, ofs[3:0]};
      end else if (ofs <= `BDM_PERIPH_LAST) begin
         if (bnk >= `BDM_REMAP_BANK_LO && bnk <= `BDM_REMAP_BANK_HI) begin
            d.kind = bdm_pkg::KIND_REMAP;                                // R3
         end else begin
            d.kind = bdm_pkg::KIND_PERIPH;                               // R2
         end
      end else if (ofs < `BDM_COMMON_FIRST) begin
         d.kind = bdm_pkg::KIND_RAM;                                     // R4
         d.idx  = 12'({7'h00, bnk} * `BDM_RAM_BYTES)
                + {5'h00, ofs - `BDM_RAM_FIRST};                         // R15
      end else begin
         d.kind = bdm_pkg::KIND_RAM;                                     // R6
         d.idx  = `BDM_COMMON_BASE + {5'h00, ofs - `BDM_COMMON_FIRST};
      end
      return d;
   endfunction : decodeAddr

   // pointer space: traditional map, linear ram, everything else empty
   function automatic bdm_pkg::bdm_dec_type decodePtr(input logic [15:0] p);
      bdm_pkg::bdm_dec_type d;
      d.kind = bdm_pkg::KIND_NONE;
      d.idx  = 12'h000;
      if (p < `BDM_PTR_TRAD_TOP) begin
         d = decodeAddr(p[11:0]);
         // pointing at an indirect port loops; treat as empty
         if (d.kind == bdm_pkg::KIND_CORE && d.idx[3:1] == 3'h0) begin
            d.kind = bdm_pkg::KIND_NONE;
         end
      end else if (p >= `BDM_PTR_LIN_BASE && p < `BDM_PTR_LIN_TOP) begin
         d.kind = bdm_pkg::KIND_RAM;                                     // R5
         d.idx  = p[11:0];
      end
      return d;
   endfunction : decodePtr

   function automatic logic [7:0] coreRead(input bdm_pkg::bdm_state_type s,
                                           input logic [3:0]            o);
      logic [7:0] v;
      v = 8'h00;                                                         // R13
      unique case (o)
         `BDM_OFS_PCLOW   : v = s.pcLow;
         `BDM_OFS_FLAGS   : v = s.flags;
         `BDM_OFS_PTR0LO  : v = s.ptr0Lo;
         `BDM_OFS_PTR0HI  : v = s.ptr0Hi;
         `BDM_OFS_PTR1LO  : v = s.ptr1Lo;
         `BDM_OFS_PTR1HI  : v = s.ptr1Hi;
         `BDM_OFS_BANK    : v = s.bank & `BDM_BANK_MASK;                 // R10
         `BDM_OFS_WORK    : v = s.work;
         `BDM_OFS_PCHIBUF : v = s.pcHiBuf & `BDM_PCHI_MASK;              // R8
         `BDM_OFS_INTCTL  : v = s.intCtl & `BDM_INTCTL_MASK;
         default          : v = 8'h00;
      endcase
      return v;
   endfunction : coreRead

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bdm_pkg::bdm_state_type s_ff;
   bdm_pkg::bdm_state_type nxt_s;
   bdm_pkg::bdm_dec_type   dec;
   logic                   ramWr;
   logic [7:0]             ramQ;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      bdm_pkg::bdm_dec_type d;
      d     = decodeAddr({s_ff.bank[4:0], accOfs});                      // R14
      if (d.kind == bdm_pkg::KIND_CORE && d.idx[3:0] == `BDM_OFS_IND0) begin
         d = decodePtr({s_ff.ptr0Hi, s_ff.ptr0Lo});                      // R7
      end else if (d.kind == bdm_pkg::KIND_CORE && d.idx[3:0] == `BDM_OFS_IND1) begin
         d = decodePtr({s_ff.ptr1Hi, s_ff.ptr1Lo});
      end
      dec   = d;
      ramWr = accWr && !accRd && d.kind == bdm_pkg::KIND_RAM;
      nxt_s = s_ff;
      nxt_s.coreVal   = (d.kind == bdm_pkg::KIND_CORE) ? coreRead(s_ff, d.idx[3:0])
                                                       : 8'h00;           // R16
      nxt_s.pendRd    = accRd;
      nxt_s.pendRam   = accRd && d.kind == bdm_pkg::KIND_RAM;
      nxt_s.rdValid   = s_ff.pendRd;
      nxt_s.rdData    = s_ff.pendRam ? ramQ : s_ff.coreVal;
      nxt_s.periphSel = (accRd || accWr) && d.kind == bdm_pkg::KIND_PERIPH; // R2
      nxt_s.remapSel  = (accRd || accWr) && d.kind == bdm_pkg::KIND_REMAP;  // R3
      if (pcLoad) begin
         nxt_s.pcLow = pcLowIn;
      end
      if (rst_b && accWr && !accRd && d.kind == bdm_pkg::KIND_CORE) begin
         unique case (d.idx[3:0])
            `BDM_OFS_PCLOW   : nxt_s.pcLow   = accWrData;                // R9
            `BDM_OFS_FLAGS   : nxt_s.flags   = (s_ff.flags & ~`BDM_FLAGS_WMASK)
                                             | (accWrData & `BDM_FLAGS_WMASK);
            `BDM_OFS_PTR0LO  : nxt_s.ptr0Lo  = accWrData;
            `BDM_OFS_PTR0HI  : nxt_s.ptr0Hi  = accWrData;
            `BDM_OFS_PTR1LO  : nxt_s.ptr1Lo  = accWrData;
            `BDM_OFS_PTR1HI  : nxt_s.ptr1Hi  = accWrData;
            `BDM_OFS_BANK    : nxt_s.bank    = accWrData & `BDM_BANK_MASK; // R10
            `BDM_OFS_WORK    : nxt_s.work    = accWrData;
            `BDM_OFS_PCHIBUF : nxt_s.pcHiBuf = accWrData & `BDM_PCHI_MASK; // R8
            `BDM_OFS_INTCTL  : nxt_s.intCtl  = accWrData & `BDM_INTCTL_MASK; // R17
            default          : nxt_s.pcLow   = nxt_s.pcLow;              // R17
         endcase
      end
      if (!rst_b) begin
         nxt_s.pcLow     = `BDM_RST_ZERO;                                // R9
         nxt_s.pcHiBuf   = `BDM_RST_ZERO;                                // R8
         nxt_s.bank      = `BDM_RST_ZERO;                                // R10
         nxt_s.ptr0Hi    = `BDM_RST_ZERO;                                // R11
         nxt_s.ptr1Hi    = `BDM_RST_ZERO;
         nxt_s.intCtl    = `BDM_RST_INTCTL;
         nxt_s.flags     = `BDM_RST_FLAGS;
         nxt_s.coreVal   = 8'h00;
         nxt_s.pendRd    = 1'b0;
         nxt_s.pendRam   = 1'b0;
         nxt_s.rdData    = 8'h00;
         nxt_s.rdValid   = 1'b0;
         nxt_s.periphSel = 1'b0;
         nxt_s.remapSel  = 1'b0;
         // other resets keep pointer lows and working register
         if (porBor) begin
            nxt_s.ptr0Lo = `BDM_RST_ZERO;                                // R11
            nxt_s.ptr1Lo = `BDM_RST_ZERO;
            nxt_s.work   = `BDM_RST_ZERO;                                // R12
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      s_ff <= nxt_s;
   end

   // ----------------------------------------------------------------
   // ram
   // ----------------------------------------------------------------
   bdm_ram u_ram (
      .clk_sys   (clk_sys),
      .wrEn      (ramWr && rst_b),
      .addr      (dec.idx),
      .wrData    (accWrData),
      .rdData_ff (ramQ)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdData_ff    = s_ff.rdData;
   assign rdValid_ff   = s_ff.rdValid;
   assign bankSel_ff   = s_ff.bank[4:0];
   assign workReg_ff   = s_ff.work;
   assign pcLow_ff     = s_ff.pcLow;
   assign pcHighBuf_ff = s_ff.pcHiBuf[6:0];
   assign intCtl_ff    = s_ff.intCtl;
   assign coreFlags_ff = s_ff.flags;
   assign periphSel_ff = s_ff.periphSel;
   assign remapSel_ff  = s_ff.remapSel;

   // ----------------------------------------------------------------
   // checks: read path
   // ----------------------------------------------------------------
   AST_RD_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
      accRd |-> ##2 rdValid_ff)
      else $error("read not answered in two cycles");
   // a stray answer would be taken by the core as data
   AST_RD_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
      rdValid_ff |-> $past(accRd, 2))
      else $error("read answer without request");
   AST_CORE_MIRROR: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
      (accRd && accOfs == 7'h09) ##1 1'b1 |=> rdData_ff == $past(workReg_ff, 2))
      else $error("working register not mirrored");
   AST_PCLOW_READ: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
      (accRd && accOfs == 7'h02) ##1 1'b1 |=> rdData_ff == $past(pcLow_ff, 2))
      else $error("pc low byte not readable");
   AST_EMPTY_READ: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
      (accRd && accOfs inside {[7'h0c:7'h1f]}) ##1 1'b1 |=> rdData_ff == 8'h00)
      else $error("peripheral region read not zero");

   // ----------------------------------------------------------------
   // checks: write path
   // ----------------------------------------------------------------
   AST_BANK_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
      (accWr && !accRd && accOfs == 7'h08 && !pcLoad)
      |=> bankSel_ff == $past(accWrData[4:0]))
      else $error("bank select not loaded");
   AST_WORK_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
      (accWr && !accRd && accOfs == 7'h09) |=> workReg_ff == $past(accWrData))
      else $error("working register not loaded");
   AST_PCHI_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
      (accWr && !accRd && accOfs == 7'h0a) |=> pcHighBuf_ff == $past(accWrData[6:0]))
      else $error("pc high buffer not loaded");
   AST_PCLOW_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
      (accWr && !accRd && accOfs == 7'h02) |=> pcLow_ff == $past(accWrData))
      else $error("bus write to pc low lost");
   // the bus write wins, so a load is only checked without one
   AST_PCLOW_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
      (pcLoad && !(accWr && !accRd)) |=> pcLow_ff == $past(pcLowIn))
      else $error("pc low load lost");
   AST_UNIMPL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R17
      (accWr && !pcLoad && accOfs inside {[7'h0c:7'h1f]})
      |=> $stable(s_ff.pcLow) && $stable(s_ff.flags) && $stable(s_ff.ptr0Lo)
      && $stable(s_ff.ptr0Hi) && $stable(s_ff.ptr1Lo) && $stable(s_ff.ptr1Hi)
      && $stable(s_ff.bank) && $stable(s_ff.work) && $stable(s_ff.pcHiBuf)
      && $stable(s_ff.intCtl))
      else $error("write to empty location changed state");

   // ----------------------------------------------------------------
   // checks: fixed fields and decode
   // ----------------------------------------------------------------
   AST_PCHI_TOP: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
      s_ff.pcHiBuf[7] == 1'b0)
      else $error("pc high buffer top bit set");
   AST_BANK_UPPER: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
      s_ff.bank[7:5] == 3'h0)
      else $error("bank select upper bits set");
   AST_FLAGS_FIXED: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
      coreFlags_ff[7:3] == 5'h03)
      else $error("core flags fixed bits wrong");
   AST_INTCTL_UNUSED: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
      intCtl_ff[5:1] == 5'h00)
      else $error("interrupt control unused bits set");
   AST_REMAP_BANKS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
      (accRd && accOfs inside {[7'h0c:7'h1f]} && bankSel_ff inside {[5'h1b:5'h1d]})
      |=> remapSel_ff && !periphSel_ff)
      else $error("remap banks not decoded");
   AST_PERIPH_BANKS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
      (accRd && accOfs inside {[7'h0c:7'h1f]} && !(bankSel_ff inside {[5'h1b:5'h1d]}))
      |=> periphSel_ff && !remapSel_ff)
      else $error("peripheral region not decoded");
   AST_RAM_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
      (accRd && accOfs inside {[7'h20:7'h7f]}) |=> !periphSel_ff && !remapSel_ff)
      else $error("ram access flagged as peripheral");

   // ----------------------------------------------------------------
   // checks: reset values
   // ----------------------------------------------------------------
   AST_RESET_CLEAR: assert property (@(posedge clk_sys) // R11
      !rst_b |=> pcLow_ff == 8'h00 && pcHighBuf_ff == 7'h00 && bankSel_ff == 5'h00
      && s_ff.ptr0Hi == 8'h00 && s_ff.ptr1Hi == 8'h00)
      else $error("reset values wrong");
   AST_WORK_KEEP: assert property (@(posedge clk_sys) // R12
      (!rst_b && !porBor) |=> workReg_ff == $past(workReg_ff)
      && s_ff.ptr0Lo == $past(s_ff.ptr0Lo))
      else $error("warm reset lost working data");
   AST_WORK_CLEAR: assert property (@(posedge clk_sys) // R12
      (!rst_b && porBor) |=> workReg_ff == 8'h00 && s_ff.ptr1Lo == 8'h00)
      else $error("cold reset left working data");

endmodule : bdm_map

// ---- bdm_defs.svh ----
// Purpose: constants of the banked data memory map
// Assumes: 12-bit data addresses, 8-bit data
// Notes:   offsets are bank-relative unless marked linear
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

// ----------------------------------------------------------------
// core register offsets
// ----------------------------------------------------------------
`define BDM_OFS_IND0      4'h0
`define BDM_OFS_IND1      4'h1
`define BDM_OFS_PCLOW     4'h2
`define BDM_OFS_FLAGS     4'h3
`define BDM_OFS_PTR0LO    4'h4
`define BDM_OFS_PTR0HI    4'h5
`define BDM_OFS_PTR1LO    4'h6
`define BDM_OFS_PTR1HI    4'h7
`define BDM_OFS_BANK      4'h8
`define BDM_OFS_WORK      4'h9
`define BDM_OFS_PCHIBUF   4'ha
`define BDM_OFS_INTCTL    4'hb

// ----------------------------------------------------------------
// region bounds within a bank
// ----------------------------------------------------------------
`define BDM_CORE_LAST     7'h0b
`define BDM_PERIPH_LAST   7'h1f
`define BDM_RAM_FIRST     7'h20
`define BDM_COMMON_FIRST  7'h70
`define BDM_RAM_BYTES     12'h050
`define BDM_COMMON_BASE   12'ha00
`define BDM_RAM_DEPTH     2576
`define BDM_REMAP_BANK_LO 5'h1b
`define BDM_REMAP_BANK_HI 5'h1d

// ----------------------------------------------------------------
// pointer space
// ----------------------------------------------------------------
`define BDM_PTR_TRAD_TOP  16'h1000
`define BDM_PTR_LIN_BASE  16'h2000
`define BDM_PTR_LIN_TOP   16'h2a00

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define BDM_BANK_MASK     8'h1f
`define BDM_PCHI_MASK     8'h7f
`define BDM_INTCTL_MASK   8'hc1
`define BDM_FLAGS_WMASK   8'h07
`define BDM_RST_ZERO      8'h00
`define BDM_RST_INTCTL    8'h01
`define BDM_RST_FLAGS     8'h18

`endif

// ---- bdm_pkg.sv ----
// Purpose: types of the banked data memory map
// Assumes: constants live in bdm_defs.svh
// Notes:   no imports; use bdm_pkg::name
package bdm_pkg;

   // ----------------------------------------------------------------
   // access target kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      KIND_NONE   = 3'h0,
      KIND_CORE   = 3'h1,
      KIND_RAM    = 3'h3,
      KIND_PERIPH = 3'h2,
      KIND_REMAP  = 3'h6
   } bdm_kind_type;

   typedef struct packed {
      bdm_kind_type kind;
      logic [11:0]  idx;
   } bdm_dec_type;

   typedef struct packed {
      logic [7:0]   pcLow;
      logic [7:0]   flags;
      logic [7:0]   ptr0Lo;
      logic [7:0]   ptr0Hi;
      logic [7:0]   ptr1Lo;
      logic [7:0]   ptr1Hi;
      logic [7:0]   bank;
      logic [7:0]   work;
      logic [7:0]   pcHiBuf;
      logic [7:0]   intCtl;
      logic [7:0]   coreVal;
      logic         pendRd;
      logic         pendRam;
      logic [7:0]   rdData;
      logic         rdValid;
      logic         periphSel;
      logic         remapSel;
   } bdm_state_type;

endpackage : bdm_pkg

// ---- bdm_ram.sv ----
// Purpose: byte storage for general purpose and common RAM
// Assumes: one access per cycle, read and write share the address
// Notes:   read data comes from a register one cycle after the request
`timescale 1ns/10ps
`include "bdm_defs.svh"

module bdm_ram (
   input  wire logic        clk_sys,
   input  wire logic        wrEn,
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wrData,
   output logic      [7:0]  rdData_ff
);

   logic [7:0] mem [0:`BDM_RAM_DEPTH-1];

   // contents are not reset; ram powers up unknown
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[addr] <= wrData;
      end
      rdData_ff <= mem[addr];
   end

endmodule : bdm_ram

// ---- bdm_core_model.sv ----
// Purpose: core-side model that issues data memory accesses
// Assumes: requests change on the falling edge of clk_sys
// Notes:   released fields show inverted values so stale data never passes
`timescale 1ns/10ps

module bdm_core_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] rdData_ff,
   input  wire logic       rdValid_ff,
   input  wire logic       periphSel_ff,
   input  wire logic       remapSel_ff,
   output logic            accRd,
   output logic            accWr,
   output logic      [6:0] accOfs,
   output logic      [7:0] accWrData,
   output logic            pcLoad,
   output logic      [7:0] pcLowIn
);
   initial begin
      accRd     = 1'b0;
      accWr     = 1'b0;
      accOfs    = 7'h00;
      accWrData = 8'h00;
      pcLoad    = 1'b0;
      pcLowIn   = 8'h00;
   end

   task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
      @(negedge clk_sys);
      accWr     = 1'b1;
      accOfs    = ofs;
      accWrData = d;
      @(negedge clk_sys);
      accWr     = 1'b0;
      accOfs    = ~ofs;
      accWrData = ~d;
   endtask : wr

   // select flags are gathered over the whole wait, not one fixed cycle
   task automatic rd(input logic [6:0] ofs, output logic [7:0] d, output logic [1:0] sel,
                     output bit ok);
      int n;
      d   = 8'h00;
      sel = 2'b00;
      ok  = 1'b0;
      @(negedge clk_sys);
      accRd  = 1'b1;
      accOfs = ofs;
      @(negedge clk_sys);
      accRd  = 1'b0;
      accOfs = ~ofs;
      for (n = 0; n < 4 && !ok; n++) begin
         sel |= {periphSel_ff, remapSel_ff};
         if (rdValid_ff === 1'b1) begin
            ok = 1'b1;
            d  = rdData_ff;
         end else begin
            @(negedge clk_sys);
         end
      end
   endtask : rd

   task automatic ld(input logic [7:0] v);
      @(negedge clk_sys);
      pcLoad  = 1'b1;
      pcLowIn = v;
      @(negedge clk_sys);
      pcLoad  = 1'b0;
      pcLowIn = ~v;
   endtask : ld

   // write and pc load in one cycle, optionally with a read on top
   task automatic mix(input logic r, input logic [6:0] ofs, input logic [7:0] d,
                      input logic [7:0] pc);
      @(negedge clk_sys);
      accRd     = r;
      accWr     = 1'b1;
      accOfs    = ofs;
      accWrData = d;
      pcLoad    = 1'b1;
      pcLowIn   = pc;
      @(negedge clk_sys);
      accRd     = 1'b0;
      accWr     = 1'b0;
      accOfs    = ~ofs;
      accWrData = ~d;
      pcLoad    = 1'b0;
      pcLowIn   = ~pc;
   endtask : mix
endmodule : bdm_core_model

// ---- banked_data_memory_map_bench.sv ----
// Purpose: self-checking bench of the banked data memory map
// Assumes: inputs change on the falling edge, synchronous reset
// Notes:   core register values come from tables indexed by offset
`timescale 1ns/10ps

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin numErrors++; \
   $display("Error %0t: got %h expected %h", $time, (a), (e)); end end

module banked_data_memory_map_bench;
   logic       clk_sys;
   logic       rst_b;
   logic       porBor;
   logic       accRd;
   logic       accWr;
   logic [6:0] accOfs;
   logic [7:0] accWrData;
   logic       pcLoad;
   logic [7:0] pcLowIn;
   logic [7:0] rdData_ff;
   logic       rdValid_ff;
   logic [4:0] bankSel_ff;
   logic [7:0] workReg_ff;
   logic [7:0] pcLow_ff;
   logic [6:0] pcHighBuf_ff;
   logic [7:0] intCtl_ff;
   logic [7:0] coreFlags_ff;
   logic       periphSel_ff;
   logic       remapSel_ff;
   int         numErrors;
   int         checks;
   logic [7:0] rstV [12] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   logic [7:0] ffV  [12] = '{8'h00, 8'h00, 8'hff, 8'h1f, 8'hff, 8'hff,
                             8'hff, 8'hff, 8'h1f, 8'hff, 8'h7f, 8'hc1};

   bdm_map u_bdm_map (.clk_sys(clk_sys), .rst_b(rst_b), .porBor(porBor), .accRd(accRd),
      .accWr(accWr), .accOfs(accOfs), .accWrData(accWrData), .pcLoad(pcLoad),
      .pcLowIn(pcLowIn), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
      .bankSel_ff(bankSel_ff), .workReg_ff(workReg_ff), .pcLow_ff(pcLow_ff),
      .pcHighBuf_ff(pcHighBuf_ff), .intCtl_ff(intCtl_ff), .coreFlags_ff(coreFlags_ff),
      .periphSel_ff(periphSel_ff), .remapSel_ff(remapSel_ff));

   bdm_core_model u_bdm_core_model (.clk_sys(clk_sys), .rdData_ff(rdData_ff),
      .rdValid_ff(rdValid_ff), .periphSel_ff(periphSel_ff), .remapSel_ff(remapSel_ff),
      .accRd(accRd), .accWr(accWr), .accOfs(accOfs), .accWrData(accWrData),
      .pcLoad(pcLoad), .pcLowIn(pcLowIn));

   always #25 clk_sys = ~clk_sys;

   task automatic stop_test();
      $display("Errors %0d checks %0d", numErrors, checks);
      if (numErrors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic rdc(input logic [6:0] ofs, input logic [7:0] e, input logic [1:0] es = 2'b00);
      logic [7:0] d;
      logic [1:0] s;
      bit         ok;
      u_bdm_core_model.rd(ofs, d, s, ok);
      if (!ok) begin
         numErrors++;
         stop_test();
      end
      `CHK(d, e)
      `CHK(s, es)
   endtask : rdc

   task automatic do_reset(input logic por);
      @(negedge clk_sys);
      rst_b  = 1'b0;
      porBor = por;
      repeat (8) @(negedge clk_sys);
      rst_b  = 1'b1;
   endtask : do_reset

   initial begin
      clk_sys   = 1'b0;
      rst_b     = 1'b0;
      porBor    = 1'b1;
      numErrors = 0;
      checks    = 0;
      do_reset(1'b1);
      // -------------------------------------------------------------
      // reset values, masks, mirroring in bank 31
      // -------------------------------------------------------------
      for (int i = 0; i < 12; i++) rdc(7'(i), rstV[i]);
      for (int i = 2; i < 12; i++) u_bdm_core_model.wr(7'(i), 8'hff);
      for (int i = 0; i < 12; i++) rdc(7'(i), ffV[i]);
      `CHK(pcHighBuf_ff, 7'h7f)
      `CHK(bankSel_ff, 5'h1f)
      `CHK(intCtl_ff, 8'hc1)
      `CHK(coreFlags_ff, 8'h1f)
      // pointer lows kept over warm reset point into common ram 0fh
      u_bdm_core_model.wr(7'h7f, 8'h6b);
      do_reset(1'b0);
      for (int i = 0; i < 12; i++)
         rdc(7'(i), (i < 2) ? 8'h6b : (i inside {4, 6, 9}) ? 8'hff : rstV[i]);
      `CHK(workReg_ff, 8'hff)
      `CHK(pcLow_ff, 8'h00)
      `CHK(coreFlags_ff, 8'h18)
      do_reset(1'b1);
      // -------------------------------------------------------------
      // banked, common and indirect RAM
      // -------------------------------------------------------------
      u_bdm_core_model.wr(7'h20, 8'ha5);
      u_bdm_core_model.wr(7'h08, 8'h01);
      u_bdm_core_model.wr(7'h20, 8'h5a);
      u_bdm_core_model.wr(7'h70, 8'h3c);
      u_bdm_core_model.wr(7'h08, 8'h00);
      rdc(7'h20, 8'ha5);
      rdc(7'h70, 8'h3c);
      u_bdm_core_model.wr(7'h04, 8'ha0);
      rdc(7'h00, 8'h5a);
      u_bdm_core_model.wr(7'h06, 8'h50);
      u_bdm_core_model.wr(7'h07, 8'h20);
      rdc(7'h01, 8'h5a);
      u_bdm_core_model.wr(7'h04, 8'h21);
      u_bdm_core_model.wr(7'h00, 8'h77);
      rdc(7'h21, 8'h77);
      u_bdm_core_model.wr(7'h07, 8'h30);
      u_bdm_core_model.wr(7'h01, 8'h99);
      rdc(7'h01, 8'h00);
      // -------------------------------------------------------------
      // peripheral and remap regions, then pc low load and its precedence against a bus write
      // -------------------------------------------------------------
      rdc(7'h0c, 8'h00, 2'b10);
      u_bdm_core_model.wr(7'h1f, 8'h55);
      rdc(7'h1f, 8'h00, 2'b10);
      for (int b = 27; b < 30; b++) begin
         u_bdm_core_model.wr(7'h08, 8'(b));
         rdc(7'h1f, 8'h00, 2'b01);
      end
      u_bdm_core_model.wr(7'h08, 8'h1e);
      rdc(7'h0c, 8'h00, 2'b10);
      rdc(7'h70, 8'h3c);
      u_bdm_core_model.ld(8'h3c);
      `CHK(pcLow_ff, 8'h3c)
      rdc(7'h02, 8'h3c);
      u_bdm_core_model.mix(1'b1, 7'h02, 8'h11, 8'h22);
      `CHK(pcLow_ff, 8'h22)
      u_bdm_core_model.mix(1'b0, 7'h02, 8'h33, 8'h44);
      `CHK(pcLow_ff, 8'h33)
      rdc(7'h02, 8'h33);
      stop_test();
   end
endmodule : banked_data_memory_map_bench
